// file: src/tec_pkg.sv
package tec_pkg;

  // ------------------------------------------------------------
  // widths and constants
  // ------------------------------------------------------------
  localparam int unsigned LOW_W   = 5;
  localparam int unsigned MID_W   = 4;
  localparam int unsigned HIGH_W  = 5;
  localparam int unsigned NIB_W   = 4;
  localparam logic [3:0]  NIB_ALL_ONES = 4'hF;
  localparam logic [3:0]  NIB_ZERO     = 4'h0;
  localparam logic [3:0]  MODE_RESET   = 4'h0;
  localparam int unsigned MODE_SRC_BIT = 0;
  localparam int unsigned TIMER_VECTOR_PAGE = 0;
  localparam logic [3:0]  TIMER_VECTOR_ADDR = 4'h8;
  localparam int unsigned RESET_MIN_CYCLES  = 3;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TEC_SRC_EVENT = 2'b00,
    TEC_SRC_TIMER = 2'b01
  } tec_src_t;

  typedef struct packed {
    logic       read_prescale_mid_op;
    logic       read_prescale_high_op;
    logic       prescale_clear_op;
    logic       reload_timer_load_op;
    logic       event_counter_load_op;
    logic       second_mode_write_op;
    logic       int_enable_op;
    logic       int_disable_op;
    logic       int_accept;
    logic [3:0] acc;
  } tec_cmd_t;

  typedef struct packed {
    logic [3:0] b_data;
    logic       b_load;
    logic [3:0] a_data;
    logic       cy_data;
    logic       a_load;
  } tec_read_t;

endpackage : tec_pkg

// file: src/tec_edge_sync.sv
`timescale 1ns/100ps
module tec_edge_sync (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic reset_n_in,
  // pin
  input  wire logic pin_in,
  // detected edge
  output logic      rise_out
);
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic next_a;
  logic next_b;
  logic next_c;

  always_comb begin
    next_a = pin_in;
    next_b = sync_a;
    next_c = sync_b;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= next_a;
      sync_b <= next_b;
      sync_c <= next_c;
    end
  end

  assign rise_out = sync_b & ~sync_c;
endmodule : tec_edge_sync

// file: src/tec_timer_event.sv
`timescale 1ns/100ps
// Notes on behaviour
// - 14-bit free prescale timer, three cascaded sections
// - reads: mid to B; high to A, CY
// - prescale clear zeroes all sections
// - reload load writes latch and counter
// - reload counter decrements every machine cycle
// - at F reload from latch
// - reload period is start value plus one
// - timer mode: event counter steps on reload F
// - event mode: step on count input rise
// - event load writes start value
// - interrupt request when event counter reaches F
// - mode bit0: 0 event, 1 timer; reset 0
// - request time is period times counts
// - reset held three cycles clears mode flag
// - vector page 0 address 8, priority mid
// - request latched while disabled; disable clears
// - mode write loads all four flags
module tec_timer_event #(
  parameter int unsigned LOW_WIDTH  = 5,
  parameter int unsigned MID_WIDTH  = 4,
  parameter int unsigned HIGH_WIDTH = 5
) (
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              reset_n_in,
  // core commands, one per machine cycle
  input  wire tec_pkg::tec_cmd_t cmd_in,
  // external count pin
  input  wire logic              external_count_input_in,
  // read answers to the core
  output tec_pkg::tec_read_t     read_out,
  // mode flags, interrupt and counter values
  output logic [3:0]             timer_mode_config_out,
  output logic                   int_request_out,
  output logic [3:0]             int_vector_out,
  output logic [3:0]             reload_timer_out,
  output logic [3:0]             event_counter_out
);
  import tec_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [LOW_WIDTH-1:0]  prescale_low_section;
  logic [MID_WIDTH-1:0]  prescale_mid_section;
  logic [HIGH_WIDTH-1:0] prescale_high_section;
  logic [LOW_WIDTH-1:0]  next_low;
  logic [MID_WIDTH-1:0]  next_mid;
  logic [HIGH_WIDTH-1:0] next_high;
  logic [3:0]            reload_latch;
  logic [3:0]            reload_timer;
  logic [3:0]            event_counter;
  logic [3:0]            timer_mode_config;
  logic                  int_latched;
  logic                  int_enabled;
  logic [3:0]            next_latch;
  logic [3:0]            next_reload;
  logic [3:0]            next_event;
  logic [3:0]            next_mode;
  logic                  next_int_latched;
  logic                  next_int_enabled;
  tec_read_t             next_read;
  tec_read_t             read_reg;
  logic                  ec_rise;
  logic                  reload_hit;
  logic                  event_step;
  tec_src_t              src;

  tec_edge_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .pin_in     (external_count_input_in),
    .rise_out   (ec_rise)
  );

  // ------------------------------------------------------------
  // prescale timer
  // ------------------------------------------------------------
  always_comb begin
    next_low  = prescale_low_section + 1'b1;
    next_mid  = prescale_mid_section;
    next_high = prescale_high_section;
    if (&prescale_low_section) begin
      next_mid = prescale_mid_section + 1'b1;
      if (&prescale_mid_section) begin
        next_high = prescale_high_section + 1'b1;
      end
    end
    if (cmd_in.prescale_clear_op) begin
      next_low  = '0;
      next_mid  = '0;
      next_high = '0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prescale_low_section  <= '0;
      prescale_mid_section  <= '0;
      prescale_high_section <= '0;
    end else begin
      prescale_low_section  <= next_low;
      prescale_mid_section  <= next_mid;
      prescale_high_section <= next_high;
    end
  end

  // ------------------------------------------------------------
  // reload timer
  // ------------------------------------------------------------
  always_comb begin
    next_reload = reload_timer - 1'b1;
    next_latch  = reload_latch;
    reload_hit  = (next_reload == NIB_ALL_ONES);
    if (reload_hit) begin
      next_reload = reload_latch;
    end
    if (cmd_in.reload_timer_load_op) begin
      next_latch  = cmd_in.acc;
      next_reload = cmd_in.acc;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reload_latch <= NIB_ZERO;
      reload_timer <= NIB_ZERO;
    end else begin
      reload_latch <= next_latch;
      reload_timer <= next_reload;
    end
  end

  // ------------------------------------------------------------
  // event counter
  // ------------------------------------------------------------
  always_comb begin
    src = timer_mode_config[MODE_SRC_BIT] ? TEC_SRC_TIMER : TEC_SRC_EVENT;
    case (src)
      TEC_SRC_TIMER: event_step = reload_hit;
      TEC_SRC_EVENT: event_step = ec_rise;
      default:       event_step = 1'b0;
    endcase
    next_event = event_step ? event_counter - 1'b1 : event_counter;
    if (cmd_in.event_counter_load_op) begin
      next_event = cmd_in.acc;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      event_counter <= NIB_ZERO;
    end else begin
      event_counter <= next_event;
    end
  end

  // ------------------------------------------------------------
  // mode flags
  // ------------------------------------------------------------
  always_comb begin
    next_mode = cmd_in.second_mode_write_op ? cmd_in.acc : timer_mode_config;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timer_mode_config <= MODE_RESET;
    end else begin
      timer_mode_config <= next_mode;
    end
  end

  // ------------------------------------------------------------
  // interrupt latch and enable
  // ------------------------------------------------------------
  always_comb begin
    next_int_enabled = int_enabled;
    if (cmd_in.int_enable_op) begin
      next_int_enabled = 1'b1;
    end
    if (cmd_in.int_disable_op) begin
      next_int_enabled = 1'b0;
    end
    next_int_latched = int_latched;
    if (cmd_in.int_disable_op || cmd_in.int_accept) begin
      next_int_latched = 1'b0;
    end
    // set wins over a clear in the same cycle
    if (event_step && (event_counter - 1'b1) == NIB_ALL_ONES
        && !cmd_in.event_counter_load_op) begin
      next_int_latched = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      int_latched <= 1'b0;
      int_enabled <= 1'b0;
    end else begin
      int_latched <= next_int_latched;
      int_enabled <= next_int_enabled;
    end
  end

  // ------------------------------------------------------------
  // read answers
  // ------------------------------------------------------------
  always_comb begin
    next_read = '0;
    next_read.b_data  = prescale_mid_section;
    next_read.b_load  = cmd_in.read_prescale_mid_op;
    next_read.a_data  = prescale_high_section[NIB_W-1:0];
    next_read.cy_data = prescale_high_section[HIGH_WIDTH-1];
    next_read.a_load  = cmd_in.read_prescale_high_op;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      read_reg <= '0;
    end else begin
      read_reg <= next_read;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic int_request;
  logic [3:0] int_vector;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      int_request <= 1'b0;
      int_vector  <= NIB_ZERO;
    end else begin
      int_request <= next_int_latched & next_int_enabled;
      int_vector  <= TIMER_VECTOR_ADDR;
    end
  end

  assign read_out              = read_reg;
  assign timer_mode_config_out = timer_mode_config;
  assign int_request_out       = int_request;
  assign int_vector_out        = int_vector;
  assign reload_timer_out      = reload_timer;
  assign event_counter_out     = event_counter;
endmodule : tec_timer_event

// file: verification/tec_props.sv
`timescale 1ns/100ps
module tec_props (
  // clock and reset
  input wire logic               ref_clk_in,
  input wire logic               reset_n_in,
  // watched ports
  input wire tec_pkg::tec_cmd_t  cmd_in,
  input wire tec_pkg::tec_read_t read_out,
  input wire logic [3:0]         timer_mode_config_out,
  input wire logic               int_request_out,
  input wire logic [3:0]         reload_timer_out,
  input wire logic [3:0]         event_counter_out
);
  import tec_pkg::*;
  logic en_q;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ------------------------------------------------------------
  // interrupt enable shadow
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) en_q <= 1'b0;
    else if (cmd_in.int_enable_op | cmd_in.int_disable_op) en_q <= !cmd_in.int_disable_op;
  end
  sequence s_hit;
    $past(event_counter_out) == NIB_ZERO && event_counter_out == NIB_ALL_ONES;
  endsequence
  property p_rl_load;
    cmd_in.reload_timer_load_op |=> reload_timer_out == $past(cmd_in.acc);
  endproperty
  a_rl_load: assert property (p_rl_load) else $error("reload load");
  property p_rl_dec;
    !cmd_in.reload_timer_load_op && reload_timer_out != NIB_ZERO
      |=> reload_timer_out == $past(reload_timer_out) - 4'h1;
  endproperty
  a_rl_dec: assert property (p_rl_dec) else $error("reload step");
  property p_ev_load;
    cmd_in.event_counter_load_op |=> event_counter_out == $past(cmd_in.acc);
  endproperty
  a_ev_load: assert property (p_ev_load) else $error("event load");
  property p_ev_timer;
    timer_mode_config_out[0] && reload_timer_out == NIB_ZERO && !cmd_in.reload_timer_load_op
      && !cmd_in.event_counter_load_op |=> event_counter_out == $past(event_counter_out) - 4'h1;
  endproperty
  a_ev_timer: assert property (p_ev_timer) else $error("timer step");
  property p_int;
    (en_q && !cmd_in.int_accept && !cmd_in.int_disable_op
      && !$past(cmd_in.event_counter_load_op)) and s_hit |=> int_request_out;
  endproperty
  a_int: assert property (p_int) else $error("no request");
  property p_int_dis;
    cmd_in.int_disable_op && event_counter_out != NIB_ZERO |-> ##2 !int_request_out;
  endproperty
  a_int_dis: assert property (p_int_dis) else $error("request kept");
  property p_mode;
    cmd_in.second_mode_write_op |=> timer_mode_config_out == $past(cmd_in.acc);
  endproperty
  a_mode: assert property (p_mode) else $error("mode write");
  property p_read;
    1'b1 |=> read_out.b_load == $past(cmd_in.read_prescale_mid_op)
      && read_out.a_load == $past(cmd_in.read_prescale_high_op);
  endproperty
  a_read: assert property (p_read) else $error("read pulse");
endmodule : tec_props
bind tec_timer_event tec_props u_props (.ref_clk_in, .reset_n_in, .cmd_in, .read_out,
  .timer_mode_config_out, .int_request_out, .reload_timer_out, .event_counter_out);

// file: verification/tec_pulse_src.sv
`timescale 1ns/100ps
module tec_pulse_src (
  // clock
  input  wire logic ref_clk_in,
  // count pin, low between bursts
  output logic      pulse_out
);
  initial pulse_out = 1'b0;
  task automatic burst(input int n, input int hp);
    repeat (n) begin
      repeat (hp) @(negedge ref_clk_in);
      pulse_out = 1'b1;
      repeat (hp) @(negedge ref_clk_in);
      pulse_out = 1'b0;
    end
  endtask : burst
endmodule : tec_pulse_src

// file: verification/test_timer_and_event_counter.sv
`timescale 1ns/100ps
module test_timer_and_event_counter;
  import tec_pkg::*;
  logic        ref_clk_in  = 1'b0;
  logic        reset_n_in  = 1'b0;
  tec_cmd_t    cmd         = '0;
  tec_read_t   rd;
  logic [3:0]  mode, vec, rl, ev, s, n;
  logic [13:0] t;
  logic        pin, irq;
  int          mismatches  = 0;
  int          comparisons = 0;
  int          k;
  always #10 ref_clk_in = ~ref_clk_in;
  tec_timer_event dut (.ref_clk_in, .reset_n_in, .cmd_in(cmd), .external_count_input_in(pin),
    .read_out(rd), .timer_mode_config_out(mode), .int_request_out(irq), .int_vector_out(vec),
    .reload_timer_out(rl), .event_counter_out(ev));
  tec_pulse_src src (.ref_clk_in, .pulse_out(pin));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] ev_left(input logic [3:0] a, input logic [3:0] b);
    return a - b;
  endfunction : ev_left
  function automatic logic [8:0] pre(input logic [13:0] c);
    return {c[8:5], c[12:9], c[13]};
  endfunction : pre
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] v);
    comparisons++;
    if (v !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, v);
    end
  endtask : chk
  task automatic op(input logic [8:0] o, input logic [3:0] a);
    @(negedge ref_clk_in);
    cmd = {o, a};
    @(negedge ref_clk_in);
    cmd = '0;
  endtask : op
  task automatic final_report;
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    mismatches++;
    final_report;
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(29));
    repeat (4) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    @(negedge ref_clk_in);
    chk("mode", 16'(MODE_RESET), 16'(mode));
    chk("vector", 16'(TIMER_VECTOR_ADDR), 16'(vec));
    for (int i = 0; i < 16; i++) begin
      op(9'h008, 4'(i));
      chk("mode", 16'(i), 16'(mode));
    end
    op(9'h004, 4'h0);
    for (int i = 0; i < 4; i++) begin
      s = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
      op(9'h031, s);
      chk("reload", 16'(s), 16'(rl));
      k = 0;
      while (irq !== 1'b1 && k < 300) begin
        @(negedge ref_clk_in);
        k++;
      end
      chk("irq time", 16'((int'(s) + 1) * (int'(s) + 1)), 16'(k));
      op(9'h001, 4'h0);
    end
    op(9'h002, 4'h0);
    op(9'h030, 4'h0);
    repeat (3) @(negedge ref_clk_in);
    op(9'h008, 4'h0);
    chk("irq", 16'(0), 16'(irq));
    op(9'h004, 4'h0);
    @(negedge ref_clk_in);
    chk("irq", 16'(1), 16'(irq));
    op(9'h002, 4'h0);
    op(9'h004, 4'h0);
    @(negedge ref_clk_in);
    chk("irq", 16'(0), 16'(irq));
    for (int i = 0; i < 4; i++) begin
      s = 4'($urandom);
      n = 4'(1 + $urandom % 8);
      op(9'h011, s);
      src.burst(n, 1 + $urandom % 4);
      repeat (4) @(negedge ref_clk_in);
      chk("events", 16'(ev_left(s, n)), 16'(ev));
      chk("irq", 16'(n > s), 16'(irq));
    end
    for (int i = 0; i < 2; i++) begin
      t = 14'(32 * ($urandom % 512) + 16);
      op(9'h040, 4'h0);
      repeat (t - 1) @(negedge ref_clk_in);
      op(9'h180, 4'h0);
      chk("prescale", 16'({pre(t), 2'b11}),
        16'({rd.b_data, rd.a_data, rd.cy_data, rd.b_load, rd.a_load}));
    end
    final_report;
  end
endmodule : test_timer_and_event_counter
